// ---- inc/rers_pkg.sv ----
// constants and types for the regulator enable and reset sequencer
package rers_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned POR_HOLD_MAX_MS = 110;
   // longest time rounds down
   localparam longint unsigned POR_HOLD_CYCLES =
      (longint'(POR_HOLD_MAX_MS) * longint'(CLK_FREQ_HZ)) / 64'd1000;
   localparam int unsigned COUNT_W = 24;

   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      RERS_POR_HOLD = 2'b00,
      RERS_RUN = 2'b01
   } rers_state_t;
endpackage

// ---- verilog/rers_sequencer.sv ----
// regulator enable and section reset sequencer behind the two enable pins
// ****************************************
// Summary of operation
// - regulators on while either enable is high, off only when both low
// - wlan section held in reset while wlan_power_enable is low
// - bluetooth section held in reset while bt_power_enable is low
// - internal power-on reset released at most 110 ms after supplies good
// ****************************************
module rers_sequencer #(
   parameter int unsigned POR_HOLD_CYCLES = 32'(rers_pkg::POR_HOLD_CYCLES)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic supplies_good,
   input wire logic wlan_power_enable,
   input wire logic bt_power_enable,
   output logic regulator_enable,
   output logic wlan_reset_n,
   output logic bt_reset_n,
   output logic por_done
);
   // ****************************************
   // helper functions
   // ****************************************
   // either enable alone is enough to keep the regulators up
   function automatic logic any_enable(input logic wlan_en, input logic bt_en);
      any_enable = wlan_en | bt_en;
   endfunction

   // a section leaves reset only with its own enable high and the hold over
   function automatic logic section_release(input logic section_en, input logic hold_over);
      section_release = section_en & hold_over;
   endfunction

   // ****************************************
   // power-on reset hold
   // ****************************************
   // a zero-length hold would wrap the compare value, so it counts as one cycle
   localparam int unsigned HOLD_LIMIT = (POR_HOLD_CYCLES == 0) ? 1 : POR_HOLD_CYCLES;
   localparam logic [rers_pkg::COUNT_W-1:0] HOLD_LAST = rers_pkg::COUNT_W'(HOLD_LIMIT - 1);

   rers_pkg::rers_state_t state;
   logic [rers_pkg::COUNT_W-1:0] por_count;
   logic por_expired;
   logic regulators_wanted;
   logic wlan_release;
   logic bt_release;

   // comparing with the last count lets por_done rise on the final edge of the hold
   assign por_expired = (por_count >= HOLD_LAST);

   // the hold restarts whenever a supply drops below threshold
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= rers_pkg::RERS_POR_HOLD;
      end else if (!supplies_good) begin
         state <= rers_pkg::RERS_POR_HOLD;
      end else begin
         case (state)
            rers_pkg::RERS_POR_HOLD: begin
               if (por_expired) begin
                  state <= rers_pkg::RERS_RUN;
               end
            end
            rers_pkg::RERS_RUN: begin
               state <= rers_pkg::RERS_RUN;
            end
            default: begin
               state <= rers_pkg::RERS_POR_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_count <= '0;
      end else if (!supplies_good || state != rers_pkg::RERS_POR_HOLD) begin
         por_count <= '0;
      end else if (!por_expired) begin
         por_count <= por_count + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_done <= 1'b0;
      end else begin
         por_done <= supplies_good && (state == rers_pkg::RERS_RUN
                     || (state == rers_pkg::RERS_POR_HOLD && por_expired));
      end
   end

   // ****************************************
   // regulator and section resets
   // ****************************************
   // no minimum-interval check on the pins: the host owns the 10 ms discharge gap
   assign regulators_wanted = any_enable(wlan_power_enable, bt_power_enable);
   assign wlan_release = section_release(wlan_power_enable, por_done);
   assign bt_release = section_release(bt_power_enable, por_done);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regulator_enable <= 1'b0;
      end else begin
         regulator_enable <= regulators_wanted;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wlan_reset_n <= 1'b0;
      end else begin
         wlan_reset_n <= wlan_release;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bt_reset_n <= 1'b0;
      end else begin
         bt_reset_n <= bt_release;
      end
   end
endmodule

// ---- sim/rers_host_model.sv ----
// host model driving the two enable outputs from its gpio
module rers_host_model #(
   parameter int OFF_GAP = 20,
   parameter int ACCESS_GAP = 7
) (
   input wire logic ref_clk,
   output logic wlan_power_enable,
   output logic bt_power_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wlan_power_enable, bt_power_enable} = 2'h0;
   // first access waits the scaled supply-to-access gap, above the hold plus one edge
   task automatic access_wait;
      repeat (ACCESS_GAP) @(posedge ref_clk);
      #1;
   endtask
   task automatic drive(input logic w, input logic b);
      @(posedge ref_clk) #1;
      {wlan_power_enable, bt_power_enable} = {w, b};
      // discharge gap, scaled down; longer waits are always allowed
      if (!w && !b) begin
         repeat (OFF_GAP) @(posedge ref_clk);
         #1;
      end
   endtask
endmodule

// ---- sim/rers_sequencer_chk.sv ----
// assertions on the sequencer ports
module rers_chk #(
   parameter int unsigned POR_HOLD_CYCLES = 5
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic supplies_good,
   input wire logic wlan_power_enable,
   input wire logic bt_power_enable,
   input wire logic regulator_enable,
   input wire logic wlan_reset_n,
   input wire logic bt_reset_n,
   input wire logic por_done
);
   int unsigned cnt;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n) cnt <= 0;
      else cnt <= !supplies_good ? 0 : (cnt < POR_HOLD_CYCLES) ? cnt + 1 : cnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // the first edge after a reset release would compare against enables seen under reset
   reg_or_a: assert property ($past(rst_n) |->
      regulator_enable == $past(wlan_power_enable | bt_power_enable))
      else $error("regulator enable wrong");
   wlan_rst_a: assert property ($past(rst_n) |->
      wlan_reset_n == $past(wlan_power_enable & por_done))
      else $error("wlan reset wrong");
   bt_rst_a: assert property ($past(rst_n) |->
      bt_reset_n == $past(bt_power_enable & por_done))
      else $error("bt reset wrong");
   por_time_a: assert property (por_done == (cnt >= POR_HOLD_CYCLES))
      else $error("power-on reset release wrong");
   cover property (por_done && wlan_reset_n);
   cover property (bt_reset_n && !wlan_reset_n);
   cover property ($fell(por_done));
   cover property (regulator_enable && !por_done);
endmodule
bind rers_sequencer rers_chk #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) chk (.*);

// ---- sim/tb_regulator_enable_reset_sequencer.sv ----
// testbench for the regulator enable and reset sequencer
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_regulator_enable_reset_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, supplies_good = 0;
   logic wlan_power_enable, bt_power_enable, regulator_enable, wlan_reset_n, bt_reset_n, por_done;
   int err_count = 0, comparisons = 0;
   always #5 ref_clk = ~ref_clk;
   rers_host_model host (.*);
   rers_sequencer #(.POR_HOLD_CYCLES(5)) DUT (.*);
   task automatic tick(int n); repeat (n) @(posedge ref_clk); #1; endtask
   task automatic t_por;
      supplies_good = 1;
      host.drive(1'b1, 1'b0);
      tick(2);
      `CHK(por_done, 1'b0)
      `CHK(regulator_enable, 1'b1)
      tick(4);
      `CHK(por_done, 1'b1)
      `CHK(wlan_reset_n, 1'b1)
      `CHK(bt_reset_n, 1'b0)
   endtask
   task automatic t_bt;
      host.drive(1'b0, 1'b1);
      tick(2);
      `CHK(wlan_reset_n, 1'b0)
      `CHK(bt_reset_n, 1'b1)
      `CHK(regulator_enable, 1'b1)
      host.drive(1'b0, 1'b0);
      `CHK(regulator_enable, 1'b0)
   endtask
   task automatic t_drop;
      host.drive(1'b1, 1'b1);
      supplies_good = 0;
      tick(3);
      `CHK(por_done, 1'b0)
      `CHK(wlan_reset_n, 1'b0)
   endtask
   task automatic t_recover;
      supplies_good = 1;
      tick(4);
      `CHK(por_done, 1'b0)
      tick(1);
      `CHK(por_done, 1'b1)
      `CHK(wlan_reset_n, 1'b0)
      tick(1);
      `CHK(wlan_reset_n, 1'b1)
      `CHK(bt_reset_n, 1'b1)
   endtask
   task automatic t_access;
      supplies_good = 0;
      tick(2);
      `CHK(por_done, 1'b0)
      supplies_good = 1;
      host.access_wait;
      `CHK(wlan_reset_n, 1'b1)
      `CHK(bt_reset_n, 1'b1)
   endtask
   task automatic t_reset;
      rst_n = 0;
      tick(1);
      `CHK({regulator_enable, wlan_reset_n, bt_reset_n, por_done}, 4'h0)
      rst_n = 1;
      tick(1);
      `CHK(regulator_enable, 1'b1)
      `CHK(por_done, 1'b0)
      tick(4);
      `CHK(por_done, 1'b1)
      `CHK(wlan_reset_n, 1'b0)
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #5000;
      err_count++;
      wrap_up;
   end
   initial begin
      tick(3);
      rst_n = 1;
      t_por;
      t_bt;
      t_drop;
      t_recover;
      t_access;
      t_reset;
      wrap_up;
   end
endmodule
